// file: verif/cas_annot_tb.sv
// testbench for the annotation and service-request block
// assumes the controller model in cas_ctl.sv; readout source follows the read address
`timescale 1ns/1ps
module cas_annot_tb;
  import cas_pkg::*;
  logic sys_clk, rst_b, prog, st_done, on_line, mask, evt, srq, show, refused;
  logic [7:0] evt_st, status, s;
  logic [7:0] q[$];
  logic [7:0] ex[$];
  cas_cmd_t cmd;
  cas_view_t view;
  logic poll, tx_ready;
  logic [3:0] rd_line;
  logic [5:0] rd_col;
  logic [7:0] readout;
  // readout source keyed by the address outputs, so a lagging address shows
  assign readout = 8'h40 + {4'h0, rd_line} + {2'b00, rd_col};
  cas_byte_t rx, tx;
  int n_errors = 0;
  int num_checks = 0;
  int n_ref = 0;
  cas_annot cas_annot_i (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CMD_I(cmd), .VIEW_I(view),
    .PROG_MODE_I(prog), .RX_I(rx), .SELF_TEST_DONE_I(st_done), .ON_LINE_I(on_line),
    .SRQ_MASK_I(mask), .EVT_STATUS_I(evt_st), .EVT_I(evt), .POLL_I(poll),
    .READOUT_CHAR_I(readout), .TX_READY_I(tx_ready), .SRQ_O(srq), .STATUS_O(status),
    .TX_O(tx), .RD_LINE_O(rd_line), .RD_COL_O(rd_col), .SHOW_O(show),
    .READ_REFUSED_O(refused));
  cas_ctl cas_ctl_i (.clk_i(sys_clk), .srq_i(srq), .status_i(status), .tx_i(tx),
    .cmd_o(cmd), .view_o(view), .poll_o(poll), .rx_o(rx), .tx_ready_o(tx_ready));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge sys_clk)
    if (refused === 1'b1)
      n_ref++;
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic pulse_evt(input logic [7:0] v);
    @(posedge sys_clk);
    evt_st <= v;
    evt <= 1'b1;
    @(posedge sys_clk);
    evt <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : pulse_evt
  task automatic rd(input int n);
    cas_ctl_i.got.delete();
    cas_ctl_i.cmd(CMD_READ, VIEW_A);
    for (int k = 0; k < 4000 && cas_ctl_i.got.size() < n; k++)
      @(posedge sys_clk);
    repeat (4) @(negedge sys_clk);
  endtask : rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power();
    @(posedge sys_clk);
    mask <= 1'b1;
    st_done <= 1'b1;
    @(posedge sys_clk);
    st_done <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(srq === 1'b1 && status === STB_POWER_ON, "power-on request");
    cas_ctl_i.poll(s);
    repeat (2) @(negedge sys_clk);
    chk(srq === 1'b0 && s === STB_POWER_ON, "poll left request");
  endtask : t_power
  task automatic t_event();
    pulse_evt(8'h42);
    chk(srq === 1'b0 && status === 8'h42, "masked event");
    cas_ctl_i.poll(s);
    chk(s === 8'h42, "masked status byte");
    mask <= 1'b0;
    pulse_evt(8'h44);
    chk(srq === 1'b1 && status === 8'h44, "event request");
    @(posedge sys_clk);
    mask <= 1'b1;
    pulse_evt(8'h46);
    chk(srq === 1'b1 && status === 8'h46, "masked event dropped request");
    cas_ctl_i.poll(s);
    repeat (2) @(negedge sys_clk);
    chk(srq === 1'b0 && s === 8'h46, "poll left event");
  endtask : t_event
  // wide line, escape codes 1 to 31 except 13, twelve lines plus one too many
  task automatic t_load_read();
    q = {};
    ex = {};
    repeat (42) q.push_back(8'h58);
    q.push_back(CR_CODE);
    for (int c = 1; c < 32; c++)
      if (c != 13)
      begin
        q.push_back(ESC_CODE);
        q.push_back(8'(c));
        if (c inside {1, 2, [4:9], [14:20], 22, 23, [25:29]})
          ex.push_back(GLYPH_FLAG | 8'(c));
      end
    ex.push_back(8'h43);
    q = {q, 8'h43, CR_CODE};
    repeat (9) q.push_back(CR_CODE);
    q = {q, 8'h4C, CR_CODE, 8'h5A, CR_CODE};
    cas_ctl_i.load(q, s);
    chk(s === STB_READY, "ready status");
    repeat (2) @(negedge sys_clk);
    chk(show === 1'b1, "annotation not shown");
    cas_ctl_i.stall = 1'b1;
    rd(656);
    chk(cas_ctl_i.got.size() == 656, "readback length");
    for (int l = 0; l < 16; l++)
      chk(cas_ctl_i.got[l*41+40] === CR_CODE, "line end");
    foreach (ex[i])
      chk(cas_ctl_i.got[123+i] === ex[i], "glyph line");
    chk(cas_ctl_i.got[121] === 8'h58 && cas_ctl_i.got[82] === 8'h58, "wide line");
    chk(cas_ctl_i.got[533] === 8'h4C && cas_ctl_i.got[574] === 8'h4E, "line 13");
    chk(cas_ctl_i.got[0] === 8'h40 && cas_ctl_i.got[656-41] === 8'h4F, "readout");
    chk(cas_ctl_i.got[46] === 8'h46 && cas_ctl_i.got[654] === 8'h76, "readout column");
  endtask : t_load_read
  task automatic t_clear();
    int n0;
    cas_ctl_i.cmd(CMD_VIEW, VIEW_IDENT);
    repeat (2) @(negedge sys_clk);
    chk(show === 1'b0, "view kept text");
    n0 = n_ref;
    rd(1);
    chk(n_ref == n0 + 1 && cas_ctl_i.got.size() == 0, "read in identity");
    cas_ctl_i.cmd(CMD_VIEW, VIEW_BOTH);
    cas_ctl_i.stall = 1'b0;
    rd(656);
    chk(cas_ctl_i.got.size() == 656, "read in combined");
    q = {8'h51, CR_CODE};
    cas_ctl_i.load(q, s);
    chk(s === STB_READY, "second ready status");
    @(posedge sys_clk);
    prog <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(show === 1'b0, "program mode kept text");
    rd(1);
    chk(n_ref == n0 + 2 && cas_ctl_i.got.size() == 0, "read in program");
    @(posedge sys_clk);
    prog <= 1'b0;
  endtask : t_clear
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    #800000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {rst_b, prog, st_done, mask, evt} = '0;
    on_line = 1'b1;
    evt_st = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_power();
    t_event();
    t_load_read();
    t_clear();
    wrap_up();
  end
endmodule : cas_annot_tb

// file: verif/cas_ctl.sv
// controller model: commands, serial polls, text stream, readback sink
// assumes the block samples its inputs on the rising clock edge
`timescale 1ns/1ps
module cas_ctl (
  input wire logic clk_i,
  input wire logic srq_i,
  input wire logic [7:0] status_i,
  input wire cas_pkg::cas_byte_t tx_i,
  output cas_pkg::cas_cmd_t cmd_o,
  output cas_pkg::cas_view_t view_o,
  output logic poll_o,
  output cas_pkg::cas_byte_t rx_o,
  output logic tx_ready_o
);
  import cas_pkg::*;
  logic [7:0] got[$];
  logic stall = 1'b0;
  logic [1:0] ph = 2'h0;
  initial
  begin
    cmd_o = CMD_NONE;
    view_o = VIEW_A;
    poll_o = 1'b0;
    rx_o = '0;
    tx_ready_o = 1'b0;
  end
  // sink stalls three cycles of four so the block must hold its byte
  always @(posedge clk_i)
  begin
    if (tx_i.valid && tx_ready_o)
      got.push_back(tx_i.data);
    ph <= ph + 2'h1;
    tx_ready_o <= !stall || (ph == 2'h0);
  end
  task automatic cmd(input cas_cmd_t c, input cas_view_t v);
    @(posedge clk_i);
    cmd_o <= c;
    view_o <= v;
    @(posedge clk_i);
    cmd_o <= CMD_NONE;
  endtask : cmd
  // status is taken before the poll strobe; the strobe clears the request
  task automatic poll(output logic [7:0] s);
    @(negedge clk_i);
    s = status_i;
    @(posedge clk_i);
    poll_o <= 1'b1;
    @(posedge clk_i);
    poll_o <= 1'b0;
  endtask : poll
  task automatic load(input logic [7:0] q[$], output logic [7:0] s);
    cmd(CMD_LOAD, VIEW_A);
    for (int k = 0; k < 10 && !srq_i; k++)
      @(posedge clk_i);
    poll(s);
    if (s !== STB_READY)
      return;
    foreach (q[i])
    begin
      @(posedge clk_i);
      rx_o <= {1'b1, q[i]};
    end
    @(posedge clk_i);
    rx_o <= {1'b0, ~rx_o.data};
  endtask : load
endmodule : cas_ctl

// file: verilog/cas_annot.sv
// annotation store, glyph decode, line readback and service request
// assumes commands arrive as one-cycle pulses, bytes as valid strobes
`timescale 1ns/1ps
// How it works
// - store twelve lines of forty characters
// - carriage return byte splits lines
// - load, view command or program clears
// - escape plus code makes one glyph
// - only listed escape codes form glyphs
// - readback sends sixteen lines, annotation 2-13
// - readback only in view_mode_a, live, combined
// - request line raised, status byte on poll
// - mask disables event requests, byte still valid
// - power-on request unmaskable after self test, raised only when on line
// - serial poll clears pending request
// - load command requests with status 213
module cas_annot
  import cas_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire cas_pkg::cas_cmd_t CMD_I,
  input wire cas_pkg::cas_view_t VIEW_I,
  input wire logic PROG_MODE_I,
  input wire cas_pkg::cas_byte_t RX_I,
  input wire logic SELF_TEST_DONE_I,
  input wire logic ON_LINE_I,
  input wire logic SRQ_MASK_I,
  input wire logic [7:0] EVT_STATUS_I,
  input wire logic EVT_I,
  input wire logic POLL_I,
  input wire logic [7:0] READOUT_CHAR_I,
  input wire logic TX_READY_I,
  output logic SRQ_O,
  output logic [7:0] STATUS_O,
  output cas_pkg::cas_byte_t TX_O,
  output logic [3:0] RD_LINE_O,
  output logic [5:0] RD_COL_O,
  output logic SHOW_O,
  output logic READ_REFUSED_O
);
  import cas_pkg::*;

  // ----------------------------------------
  // annotation storage
  // ----------------------------------------
  logic [7:0] mem_q [ANN_LINES*LINE_CHARS];
  logic [3:0] wr_line_q;
  logic [5:0] wr_col_q;
  logic esc_q;
  logic loading_q;
  logic [7:0] glyph_d;
  logic glyph_ok;

  always_comb
  begin
    glyph_ok = GLYPH_SET[RX_I.data[4:0]] && (RX_I.data[7:5] == 3'h0);
    glyph_d = GLYPH_FLAG | RX_I.data;
  end

  wire logic wr_room = (wr_line_q < 4'(ANN_LINES)) && (wr_col_q < 6'(LINE_CHARS));

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      wr_line_q <= 4'h0;
      wr_col_q <= 6'h00;
      esc_q <= 1'b0;
      loading_q <= 1'b0;
    end
    else if (CMD_I == CMD_LOAD)
    begin
      wr_line_q <= 4'h0;
      wr_col_q <= 6'h00;
      esc_q <= 1'b0;
      loading_q <= 1'b1;
    end
    else if ((CMD_I == CMD_VIEW) || PROG_MODE_I)
      loading_q <= 1'b0;
    else if (loading_q && RX_I.valid)
    begin
      if (esc_q)
      begin
        esc_q <= 1'b0;
        if (glyph_ok && wr_room)
          wr_col_q <= wr_col_q + 6'h01;
      end
      else if (RX_I.data == ESC_CODE)
        esc_q <= 1'b1;
      else if (RX_I.data == CR_CODE)
      begin
        wr_col_q <= 6'h00;
        if (wr_line_q < 4'(ANN_LINES))
          wr_line_q <= wr_line_q + 4'h1;
      end
      else if (wr_room)
        wr_col_q <= wr_col_q + 6'h01;
    end
  end

  wire logic [8:0] wr_idx = 9'(wr_line_q * LINE_CHARS + wr_col_q);
  wire logic clr_all = (CMD_I == CMD_LOAD) || (CMD_I == CMD_VIEW) || PROG_MODE_I;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      for (int i = 0; i < ANN_LINES*LINE_CHARS; i++)
        mem_q[i] <= BLANK_CHAR;
    else if (clr_all)
      for (int i = 0; i < ANN_LINES*LINE_CHARS; i++)
        mem_q[i] <= BLANK_CHAR;
    else if (loading_q && RX_I.valid && wr_room)
    begin
      if (esc_q && glyph_ok)
        mem_q[wr_idx] <= glyph_d;
      else if (!esc_q && RX_I.data != ESC_CODE && RX_I.data != CR_CODE)
        mem_q[wr_idx] <= RX_I.data;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      SHOW_O <= 1'b0;
    else if ((CMD_I == CMD_VIEW) || PROG_MODE_I)
      SHOW_O <= 1'b0;
    else if (CMD_I == CMD_LOAD)
      SHOW_O <= 1'b1;
  end

  // ----------------------------------------
  // readback of all display lines
  // ----------------------------------------
  cas_view_t view_q;
  logic rd_busy_q;
  logic [3:0] rd_line_q;
  logic [5:0] rd_col_q;
  wire logic view_ok = (view_q != VIEW_IDENT) && !PROG_MODE_I;
  wire logic ann_line = (rd_line_q >= 4'(FIRST_ANN_LINE))
                        && (rd_line_q < 4'(FIRST_ANN_LINE + ANN_LINES));
  wire logic [3:0] ann_row = rd_line_q - 4'(FIRST_ANN_LINE);
  wire logic [8:0] rd_idx = 9'(ann_row * LINE_CHARS + rd_col_q);

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      view_q <= VIEW_A;
    else if (CMD_I == CMD_VIEW)
      view_q <= VIEW_I;
  end

  // readout lines come from outside, looked up from the address outputs;
  // those mirror the read pointer so the character matches its slot
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      rd_busy_q <= 1'b0;
      rd_line_q <= 4'h0;
      rd_col_q <= 6'h00;
      TX_O <= '0;
      READ_REFUSED_O <= 1'b0;
      RD_LINE_O <= 4'h0;
      RD_COL_O <= 6'h00;
    end
    else
    begin
      READ_REFUSED_O <= (CMD_I == CMD_READ) && !view_ok;
      if (TX_O.valid && TX_READY_I)
        TX_O.valid <= 1'b0;
      if (CMD_I == CMD_READ && view_ok && !rd_busy_q)
      begin
        rd_busy_q <= 1'b1;
        rd_line_q <= 4'h0;
        rd_col_q <= 6'h00;
        RD_LINE_O <= 4'h0;
        RD_COL_O <= 6'h00;
      end
      else if (rd_busy_q && (!TX_O.valid || TX_READY_I))
      begin
        TX_O.valid <= 1'b1;
        if (rd_col_q == 6'(LINE_CHARS))
          TX_O.data <= CR_CODE;
        else
          TX_O.data <= ann_line ? mem_q[rd_idx] : READOUT_CHAR_I;
        if (rd_col_q == 6'(LINE_CHARS))
        begin
          rd_col_q <= 6'h00;
          rd_line_q <= rd_line_q + 4'h1;
          RD_COL_O <= 6'h00;
          RD_LINE_O <= rd_line_q + 4'h1;
          if (rd_line_q == 4'(DISP_LINES - 1))
            rd_busy_q <= 1'b0;
        end
        else
        begin
          rd_col_q <= rd_col_q + 6'h01;
          RD_COL_O <= rd_col_q + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // service request and status byte
  // ----------------------------------------
  logic pwr_done_q;
  // set wins over poll clear so no request is lost
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      SRQ_O <= 1'b0;
      STATUS_O <= 8'h00;
      pwr_done_q <= 1'b0;
    end
    else
    begin
      if (SELF_TEST_DONE_I && !pwr_done_q)
        pwr_done_q <= 1'b1;
      if (SELF_TEST_DONE_I && !pwr_done_q && ON_LINE_I)
      begin
        SRQ_O <= 1'b1;
        STATUS_O <= STB_POWER_ON;
      end
      else if (CMD_I == CMD_LOAD)
      begin
        SRQ_O <= 1'b1;
        STATUS_O <= STB_READY;
      end
      else if (EVT_I)
      begin
        // a masked event must not drop a request already pending
        SRQ_O <= SRQ_O || !SRQ_MASK_I;
        STATUS_O <= EVT_STATUS_I;
      end
      else if (POLL_I)
        SRQ_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  load_srq_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (CMD_I == CMD_LOAD) && !(SELF_TEST_DONE_I && !pwr_done_q && ON_LINE_I)
    |=> SRQ_O && STATUS_O == STB_READY)
    else $error("load did not raise ready request");
  poll_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    POLL_I && CMD_I != CMD_LOAD && !EVT_I && !(SELF_TEST_DONE_I && !pwr_done_q) |=> !SRQ_O)
    else $error("poll did not clear request");
  pwr_srq_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    SELF_TEST_DONE_I && !pwr_done_q && ON_LINE_I |=> SRQ_O && STATUS_O == STB_POWER_ON)
    else $error("power-on request missing");
  mask_srq_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    EVT_I && SRQ_MASK_I && CMD_I != CMD_LOAD && !(SELF_TEST_DONE_I && !pwr_done_q)
    |=> SRQ_O == $past(SRQ_O) && STATUS_O == $past(EVT_STATUS_I))
    else $error("masked event handled wrong");
  view_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    (CMD_I == CMD_VIEW) || PROG_MODE_I |=> !SHOW_O && mem_q[0] == BLANK_CHAR)
    else $error("annotation not cleared");
  read_refuse_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    CMD_I == CMD_READ && !view_ok && !rd_busy_q |=> READ_REFUSED_O ##1 !rd_busy_q)
    else $error("readback ran in wrong mode");
  read_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    CMD_I == CMD_READ && view_ok && !rd_busy_q |=> rd_busy_q ##1 TX_O.valid)
    else $error("readback did not start");
  bound_wr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    wr_line_q <= 4'(ANN_LINES) && wr_col_q <= 6'(LINE_CHARS))
    else $error("write pointer out of range");
  cr_split_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    loading_q && RX_I.valid && !esc_q && RX_I.data == CR_CODE && CMD_I != CMD_LOAD
    |=> wr_col_q == 6'h00)
    else $error("line break not taken");
  cov_load_c: cover property (@(posedge SYS_CLK_I) CMD_I == CMD_LOAD ##[1:20] POLL_I);
  cov_glyph_c: cover property (@(posedge SYS_CLK_I) esc_q && RX_I.valid && glyph_ok);
  cov_read_c: cover property (@(posedge SYS_CLK_I) rd_busy_q ##1 !rd_busy_q);
endmodule : cas_annot

// file: verilog/cas_pkg.sv
// package for the annotation / service-request command block
// assumes a byte-wide command decoder and bus handshake logic sit outside
package cas_pkg;
  localparam int ANN_LINES = 12;
  localparam int LINE_CHARS = 40;
  localparam int DISP_LINES = 16;
  localparam int FIRST_ANN_LINE = 2;
  localparam logic [7:0] CR_CODE = 8'h0D;
  localparam logic [7:0] ESC_CODE = 8'h1B;
  localparam logic [7:0] STB_READY = 8'hD5;
  localparam logic [7:0] STB_POWER_ON = 8'h41;
  localparam logic [7:0] GLYPH_FLAG = 8'h80;
  localparam logic [7:0] BLANK_CHAR = 8'h20;
  localparam logic [31:0] GLYPH_SET = 32'h3EDFC3F6;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_LOAD = 3'h1,
    CMD_READ = 3'h2,
    CMD_VIEW = 3'h3
  } cas_cmd_t;

  typedef enum logic [1:0] {
    VIEW_A = 2'h0,
    VIEW_LIVE = 2'h1,
    VIEW_BOTH = 2'h2,
    VIEW_IDENT = 2'h3
  } cas_view_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cas_byte_t;
endpackage : cas_pkg
